// *** core/wdri_core.v ***
// Watchdog register interface with counting logic driven by a sampled count clock
`timescale 1ns/100ps
`default_nettype none
`include "wdri_defines.vh"

module wdri_core #(
    parameter SYNC_TICKS = `WDRI_SYNC_TICKS,
    parameter RST_HOLD_TICKS = `WDRI_RST_HOLD_TICKS
) (
    input wire clk,
    input wire srst,
    input wire [3:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire [3:0] bus_be,
    input wire bus_wr,
    input wire bus_rd,
    output reg [31:0] bus_rdata,
    output wire bus_stall,
    input wire wr_protect,
    input wire [7:0] boot_ctrl,
    input wire [7:0] boot_config,
    input wire [7:0] boot_wd_early_alert_control,
    input wire wd_count_clock,
    output wire irq,
    output reg sys_reset_req,
    output wire wd_running
);

    // Register state
    reg lock_reg;
    reg wen_reg;
    reg en_reg;
    reg [7:0] config_reg;
    reg [3:0] wd_early_alert_control_reg;
    reg ie_reg;
    reg flag_reg;
    reg busy_reg;
    reg [1:0] sync_cnt_reg;
    reg lock_eff_reg;
    reg en_eff_reg;
    reg clr_req_reg;
    reg [7:0] clr_val_reg;
    // Held write for a stalled access
    reg pend_reg;
    reg [3:0] pend_addr_reg;
    reg [31:0] pend_data_reg;
    reg [3:0] pend_be_reg;
    // Count clock sampling
    reg cc_s1_reg;
    reg cc_s2_reg;
    reg cc_s3_reg;
    reg cc_level_reg;
    // Counting state
    reg [14:0] cnt_reg;
    reg closed_reg;
    reg [1:0] rst_hold_reg;

    // Period for a code; reserved codes clamp to the longest setting
    function [14:0] span;
        input [3:0] code;
        begin
            if (code > `WDRI_CODE_MAX) begin
                span = `WDRI_BASE_PERIOD << `WDRI_CODE_MAX; // RQ24
            end else begin
                span = `WDRI_BASE_PERIOD << code; // RQ9 RQ10 RQ11
            end
        end
    endfunction

    // Count clock rising edge counts once the second and third stages agree
    wire cc_agree = (cc_s2_reg == cc_s3_reg);
    wire tick = cc_agree && cc_s3_reg && !cc_level_reg;

    always @(posedge clk) begin
        if (srst) begin
            cc_s1_reg <= 1'b0;
            cc_s2_reg <= 1'b0;
            cc_s3_reg <= 1'b0;
            cc_level_reg <= 1'b0;
        end else begin
            cc_s1_reg <= wd_count_clock;
            cc_s2_reg <= cc_s1_reg;
            cc_s3_reg <= cc_s2_reg;
            if (cc_agree) begin
                cc_level_reg <= cc_s3_reg;
            end
        end
    end

    // A bus write that touches a synchronised byte lane
    wire bus_sync_lane = (bus_addr[3:2] == `WDRI_OFF_CTRL >> 2 && (bus_be[0] || bus_be[1]))
        || (bus_addr[3:2] == `WDRI_OFF_SERVICE >> 2 && bus_be[0]);
    wire stall_now = bus_wr && busy_reg && bus_sync_lane; // RQ22
    wire replay = pend_reg && !busy_reg;
    assign bus_stall = pend_reg;

    // Effective write: direct, or the held one replayed once busy drops
    wire wr_go = (bus_wr && !stall_now && !pend_reg) || replay;
    wire [3:0] w_addr = replay ? pend_addr_reg : bus_addr;
    wire [31:0] w_data = replay ? pend_data_reg : bus_wdata;
    wire [3:0] w_be = replay ? pend_be_reg : bus_be;

    // Per-byte write strobes over the word lanes
    wire w_word0 = wr_go && w_addr[3:2] == 2'h0;
    wire w_word1 = wr_go && w_addr[3:2] == 2'h1;
    wire w_word2 = wr_go && w_addr[3:2] == 2'h2;
    wire we_ctrl = w_word0 && w_be[0] && !wr_protect; // RQ1 RQ18
    wire we_config = w_word0 && w_be[1] && !wr_protect; // RQ18
    wire we_wd_early_alert_control = w_word0 && w_be[2] && !wr_protect; // RQ18
    wire we_ieclr = w_word1 && w_be[0] && !wr_protect; // RQ18
    wire we_ieset = w_word1 && w_be[1] && !wr_protect; // RQ18
    wire we_flag = w_word1 && w_be[2]; // Flag ignores write protect
    wire we_service = w_word2 && w_be[0] && !wr_protect; // RQ18
    wire [7:0] d_ctrl = w_data[7:0];
    wire [7:0] d_config = w_data[15:8];
    wire [7:0] d_wd_early_alert_control = w_data[23:16];
    wire [7:0] d_ieclr = w_data[7:0];
    wire [7:0] d_ieset = w_data[15:8];
    wire [7:0] d_flag = w_data[23:16];
    wire [7:0] d_service = w_data[7:0];

    // Enable protection watches both the written and the live enable
    wire cfg_open = !lock_reg && !en_reg && !en_eff_reg; // RQ3 RQ17
    wire ctrl_ok = we_ctrl && !lock_reg; // RQ3 RQ7
    wire config_ok = we_config && cfg_open; // RQ17
    wire wd_early_alert_control_ok = we_wd_early_alert_control && cfg_open; // RQ17
    wire sync_start = ctrl_ok || config_ok || we_service; // RQ16
    wire sync_done = busy_reg && tick && sync_cnt_reg == SYNC_TICKS - 1;

    // Counting derived values
    wire running = en_eff_reg || lock_eff_reg;
    assign wd_running = running;
    wire [14:0] cnt_inc = cnt_reg + 15'h0001;
    wire [14:0] win_len = span(config_reg[7:4]);
    wire [14:0] per_len = span(config_reg[3:0]);
    wire [14:0] ew_len = span(wd_early_alert_control_reg);
    wire svc_seen = sync_done && clr_req_reg && running;
    wire svc_key = (clr_val_reg == `WDRI_SERVICE_KEY);
    wire svc_ok = svc_seen && svc_key && !closed_reg; // RQ19
    wire svc_bad = svc_seen && (!svc_key || closed_reg); // RQ19 RQ20
    wire count_step = running && tick && !svc_seen;
    wire to_hit = count_step && !closed_reg && cnt_inc == per_len; // RQ23
    wire ew_hit = count_step && (closed_reg ? cnt_inc == win_len
        : (!wen_reg && cnt_inc == ew_len)); // RQ11
    wire rst_trigger = to_hit || svc_bad;

    // Control, configuration and early alert registers, loaded from the boot row at reset
    always @(posedge clk) begin
        if (srst) begin
            lock_reg <= boot_ctrl[`WDRI_CTRL_LOCK_BIT]; // RQ5
            wen_reg <= boot_ctrl[`WDRI_CTRL_WEN_BIT];
            en_reg <= boot_ctrl[`WDRI_CTRL_EN_BIT];
            config_reg <= boot_config; // RQ5
            wd_early_alert_control_reg <= boot_wd_early_alert_control[3:0]; // RQ5
        end else begin
            if (ctrl_ok) begin
                lock_reg <= lock_reg | d_ctrl[`WDRI_CTRL_LOCK_BIT]; // RQ2 RQ4
                en_reg <= d_ctrl[`WDRI_CTRL_EN_BIT]; // RQ4 RQ7 RQ8
                if (!en_reg && !en_eff_reg) begin
                    wen_reg <= d_ctrl[`WDRI_CTRL_WEN_BIT]; // RQ6
                end
            end
            if (config_ok) begin
                config_reg <= d_config;
            end
            if (wd_early_alert_control_ok) begin
                wd_early_alert_control_reg <= d_wd_early_alert_control[3:0];
            end
        end
    end

    // Synchronisation: busy spans a fixed number of count-clock ticks.
    // A stopped count clock leaves busy high; software must keep it running.
    always @(posedge clk) begin
        if (srst) begin
            busy_reg <= 1'b0;
            sync_cnt_reg <= 2'h0;
            lock_eff_reg <= boot_ctrl[`WDRI_CTRL_LOCK_BIT];
            en_eff_reg <= boot_ctrl[`WDRI_CTRL_EN_BIT];
            clr_req_reg <= 1'b0;
            clr_val_reg <= 8'h00;
        end else begin
            if (sync_done) begin
                lock_eff_reg <= lock_reg; // RQ8
                en_eff_reg <= en_reg; // RQ8
                clr_req_reg <= 1'b0;
            end
            if (we_service) begin
                clr_req_reg <= 1'b1; // RQ16
                clr_val_reg <= d_service;
            end
            // A new start wins over a finishing one
            if (sync_start) begin
                busy_reg <= 1'b1; // RQ15
                sync_cnt_reg <= 2'h0;
            end else if (sync_done) begin
                busy_reg <= 1'b0; // RQ15
            end else if (busy_reg && tick) begin
                sync_cnt_reg <= sync_cnt_reg + 2'h1;
            end
        end
    end

    // Hold a synchronised write issued while busy and replay it afterwards
    always @(posedge clk) begin
        if (srst) begin
            pend_reg <= 1'b0;
            pend_addr_reg <= 4'h0;
            pend_data_reg <= 32'h00000000;
            pend_be_reg <= 4'h0;
        end else if (stall_now && !pend_reg) begin
            pend_reg <= 1'b1; // RQ22
            pend_addr_reg <= bus_addr;
            pend_data_reg <= bus_wdata;
            pend_be_reg <= bus_be;
        end else if (replay) begin
            pend_reg <= 1'b0; // RQ22
        end
    end

    // Interrupt enable and flag; the event wins over a clearing write
    always @(posedge clk) begin
        if (srst) begin
            ie_reg <= `WDRI_IE_RESET;
            flag_reg <= `WDRI_FLAG_RESET;
        end else begin
            if (we_ieset && d_ieset[`WDRI_EW_BIT]) begin
                ie_reg <= 1'b1; // RQ13
            end else if (we_ieclr && d_ieclr[`WDRI_EW_BIT]) begin
                ie_reg <= 1'b0; // RQ12
            end
            if (ew_hit) begin
                flag_reg <= 1'b1; // RQ14
            end else if (we_flag && d_flag[`WDRI_EW_BIT]) begin
                flag_reg <= 1'b0; // RQ14
            end
        end
    end

    assign irq = flag_reg && ie_reg; // RQ21

    // Period counter: closed window first in window mode, then open or normal period
    always @(posedge clk) begin
        if (srst) begin
            cnt_reg <= 15'h0000;
            closed_reg <= 1'b0;
        end else if (!running) begin
            cnt_reg <= 15'h0000;
            closed_reg <= wen_reg; // RQ6
        end else if (svc_ok || svc_bad) begin
            // A bad service restarts the period too, behind its reset request
            cnt_reg <= 15'h0000; // RQ19
            closed_reg <= wen_reg;
        end else if (tick) begin
            if (closed_reg && cnt_inc == win_len) begin
                cnt_reg <= 15'h0000; // RQ9
                closed_reg <= 1'b0;
            end else if (!closed_reg && cnt_inc == per_len) begin
                cnt_reg <= 15'h0000; // RQ10
                closed_reg <= wen_reg;
            end else begin
                cnt_reg <= cnt_inc;
            end
        end
    end

    // Reset request stays high across at least one full count-clock cycle
    always @(posedge clk) begin
        if (srst) begin
            sys_reset_req <= 1'b0;
            rst_hold_reg <= 2'h0;
        end else if (rst_trigger) begin
            sys_reset_req <= 1'b1; // RQ23
            rst_hold_reg <= RST_HOLD_TICKS[1:0];
        end else if (sys_reset_req && tick) begin
            if (rst_hold_reg == 2'h1) begin
                sys_reset_req <= 1'b0;
            end
            rst_hold_reg <= rst_hold_reg - 2'h1;
        end
    end

    // Read data one cycle after the strobe; the whole word is returned
    always @(posedge clk) begin
        if (srst) begin
            bus_rdata <= 32'h00000000;
        end else if (bus_rd) begin
            if (bus_addr[3:2] == 2'h0) begin
                bus_rdata <= {8'h00, 4'h0, wd_early_alert_control_reg, config_reg,
                    lock_reg, 4'h0, wen_reg, en_reg, 1'b0};
            end else if (bus_addr[3:2] == 2'h1) begin
                bus_rdata <= {busy_reg, 7'h00, 7'h00, flag_reg,
                    7'h00, ie_reg, 7'h00, ie_reg}; // RQ12 RQ13 RQ15
            end else begin
                bus_rdata <= 32'h00000000; // Service key and unmapped read zero
            end
        end else begin
            bus_rdata <= 32'h00000000;
        end
    end

endmodule // wdri_core
`default_nettype wire

// *** core/wdri_defines.vh ***
// Register map, field positions, reset values and timing counts of the watchdog register block
// How it works
// RQ1: Byte enables allow 8, 16 and 32 bit accesses and direct byte or halfword access.
// RQ2: Once the run lock is set, writing zero keeps it; only reset clears it.
// RQ3: With the run lock set, control, timing and early alert writes are ignored.
// RQ4: Run lock and enable bits are writable whether or not the watchdog runs.
// RQ5: Control, timing and early alert registers load from the boot row at reset.
// RQ6: Control bit 2 selects normal or closed-then-open window servicing.
// RQ7: Control bit 1 turns the watchdog on or off, only while unlocked.
// RQ8: Enable reads back at once, sets busy, takes effect after synchronisation.
// RQ9: Timing bits 7:4 set closed window, 8 doubling to 16384 count cycles.
// RQ10: Timing bits 3:0 set time-out or open window with the same doubling code.
// RQ11: Early alert bits 3:0 set when early alert fires after the period starts; in window mode the code fires it when the closed window ends instead.
// RQ12: Writing one to enable-clear bit 0 disables the early alert interrupt.
// RQ13: Writing one to enable-set bit 0 enables the early alert interrupt.
// RQ14: Early alert flag sets on the event; writing one clears it.
// RQ15: Status bit 7 shows synchronisation pending, high from start to finish.
// RQ16: Control, timing and service writes pass a synchronisation step; early alert does not.
// RQ17: Timing and early alert registers accept writes only while the watchdog is off.
// RQ18: Write protect input blocks all writable registers except flag and status.
// RQ19: Service key 0xA5 restarts the period; any other value requests a reset.
// RQ20: A valid service during the closed window requests a reset instead.
// RQ21: Interrupt output is high while flag and enable are both set.
// RQ22: A synchronised write issued while busy stalls and completes after busy clears.
// RQ23: Time-out without service raises reset request for at least one count cycle.
// RQ24: Reserved period codes behave as the longest setting of 16384 cycles.
`ifndef WDRI_DEFINES_VH
`define WDRI_DEFINES_VH

// Byte offsets of the registers
`define WDRI_OFF_CTRL 4'h0
`define WDRI_OFF_CONFIG 4'h1
`define WDRI_OFF_WD_EARLY_ALERT_CONTROL 4'h2
`define WDRI_OFF_IECLR 4'h4
`define WDRI_OFF_IESET 4'h5
`define WDRI_OFF_FLAG 4'h6
`define WDRI_OFF_STATUS 4'h7
`define WDRI_OFF_SERVICE 4'h8

// Field positions
`define WDRI_CTRL_LOCK_BIT 7
`define WDRI_CTRL_WEN_BIT 2
`define WDRI_CTRL_EN_BIT 1
`define WDRI_STATUS_BUSY_BIT 7
`define WDRI_EW_BIT 0

// Reset values and codes
`define WDRI_IE_RESET 1'h0
`define WDRI_FLAG_RESET 1'h0
`define WDRI_SERVICE_KEY 8'hA5
`define WDRI_CODE_MAX 4'hB
`define WDRI_BASE_PERIOD 15'h0008

// Timing counts in count-clock cycles
`define WDRI_SYNC_TICKS 2
`define WDRI_RST_HOLD_TICKS 2

`endif

// *** sim/wdri_core_assertions.sv ***
// Port-level checker for the watchdog register block, bound to the core
`timescale 1ns/100ps
`default_nettype none
module wdri_chk #(
    parameter SYNC_TICKS = 2,
    parameter RST_HOLD_TICKS = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic [3:0] bus_be,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_stall,
    input wire logic wr_protect,
    input wire logic irq,
    input wire logic sys_reset_req,
    input wire logic wd_running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Accepted control write, then back to back reads of word 0 and word 1
    sequence s_ctl_wr;
        bus_wr && bus_addr[3:2] == 2'h0 && bus_be[0] && !bus_stall && !wr_protect;
    endsequence
    sequence s_rd_w0;
        bus_rd && bus_addr[3:2] == 2'h0;
    endsequence
    sequence s_rd_w1;
        bus_rd && bus_addr[3:2] == 2'h1;
    endsequence
    a_rdata_idle_zero: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    a_enable_readback: assert property (s_ctl_wr ##1 s_rd_w0 |=> bus_rdata[1] == $past(bus_wdata[1], 2))
        else $error("enable bit did not read back at once");
    a_busy_shown: assert property (s_ctl_wr ##1 s_rd_w0 ##1 s_rd_w1 |=> bus_rdata[31])
        else $error("busy flag low right after a control write");
    a_enable_delayed: assert property (s_ctl_wr |=> $stable(wd_running))
        else $error("running state changed without synchronisation");
    a_ieclr_drops_irq: assert property (bus_wr && bus_addr[3:2] == 2'h1 && bus_be[0] && bus_wdata[0]
        && !bus_stall && !wr_protect |=> !irq)
        else $error("interrupt stayed high after enable clear");
    a_stall_cause: assert property ($rose(bus_stall) |-> $past(bus_wr))
        else $error("stall rose without a write");
    a_stall_bounded: assert property ($rose(bus_stall) |-> ##[1:200] !bus_stall)
        else $error("stall did not end");
    a_req_held: assert property ($rose(sys_reset_req) |-> sys_reset_req[*3])
        else $error("reset request too short");
    a_reset_quiet: assert property ($fell(srst) |-> !irq && !sys_reset_req && !bus_stall)
        else $error("outputs active right after reset");
endmodule // wdri_chk
bind wdri_core wdri_chk #(.SYNC_TICKS(SYNC_TICKS), .RST_HOLD_TICKS(RST_HOLD_TICKS)) chk_u (
    .clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_be(bus_be),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .bus_stall(bus_stall),
    .wr_protect(wr_protect), .irq(irq), .sys_reset_req(sys_reset_req), .wd_running(wd_running));
`default_nettype wire

// *** sim/watchdog_register_interface_bench.sv ***
// Self-checking bench for the watchdog register block
`timescale 1ns/100ps
`default_nettype none
module watchdog_register_interface_bench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] bus_addr = 4'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic [3:0] bus_be = 4'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic wr_protect = 1'b0;
    logic [7:0] boot_ctrl = 8'h00;
    logic [7:0] boot_config = 8'h00;
    logic [7:0] boot_wd_early_alert_control = 8'h00;
    logic cnt_clk = 1'b0;
    logic [31:0] bus_rdata;
    logic bus_stall, irq, sys_reset_req, wd_running;
    logic rd_seen = 1'b0;
    logic [63:0] notes[$];
    logic [63:0] note;
    logic [7:0] cfg_rand;
    int failures = 0;
    int cmp_count = 0;

    // Bus clock and an unrelated, slower count clock
    always #2 clk = ~clk;
    always #15 cnt_clk = ~cnt_clk;

    wdri_core dut_u (.clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_be(bus_be), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .bus_stall(bus_stall), .wr_protect(wr_protect), .boot_ctrl(boot_ctrl),
        .boot_config(boot_config), .boot_wd_early_alert_control(boot_wd_early_alert_control), .wd_count_clock(cnt_clk),
        .irq(irq), .sys_reset_req(sys_reset_req), .wd_running(wd_running));

    // Compares each answer with the oldest note at the falling edge, where read data has settled
    always @(negedge clk) begin
        if (rd_seen && notes.size() == 0) begin
            failures++;
            $display("[FAIL] rdata expected a note seen %h", bus_rdata);
        end else if (rd_seen) begin
            note = notes.pop_front();
            cmp_count++;
            if ((bus_rdata & note[63:32]) !== note[31:0]) begin
                failures++;
                $display("[FAIL] rdata expected %h mask %h seen %h", note[31:0], note[63:32], bus_rdata);
            end
        end
        rd_seen <= bus_rd;
    end

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // A write issued while stall is high would be lost, so wait it out first.
    // Stall seen here predates this edge: after a held write, wait on it explicitly.
    task automatic wr(input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
        int n;
        n = 0;
        while (bus_stall !== 1'b0) begin
            n++;
            if (n > 300) begin
                $display("[FAIL] bus_stall expected 0 seen %b", bus_stall);
                failures++;
                close_out();
            end
            bus_wr <= 1'b0;
            bus_rd <= 1'b0;
            @(posedge clk);
        end
        bus_addr <= a;
        bus_be <= be;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        bus_rd <= 1'b0;
        @(posedge clk);
    endtask

    // Strobes stay up after the edge; the next call or a wait lowers them
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        bus_addr <= a;
        bus_rd <= 1'b1;
        bus_wr <= 1'b0;
        notes.push_back({m, e & m});
        @(posedge clk);
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return wd_running;
            1: return irq;
            2: return sys_reset_req;
            default: return bus_stall;
        endcase
    endfunction

    // Outputs are looked at on the falling edge; returns on a rising edge
    task automatic wait_for(input int k, input logic v, input int lim);
        int n;
        n = 0;
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        @(negedge clk);
        while (pick(k) !== v) begin
            n++;
            if (n > lim) begin
                $display("[FAIL] output %0d expected %b seen %b", k, v, pick(k));
                failures++;
                close_out();
            end
            @(negedge clk);
        end
        cmp_count++;
        @(posedge clk);
    endtask

    // Polls the status byte until no synchronisation is pending
    task automatic idle;
        int n;
        logic done;
        for (n = 0; n < 100; n++) begin
            rd(4'h4, 32'h0, 32'h0);
            bus_rd <= 1'b0;
            @(negedge clk);
            done = (bus_rdata[31] === 1'b0);
            @(posedge clk);
            if (done) return;
        end
        $display("[FAIL] busy expected 0 seen %b", bus_rdata[31]);
        failures++;
        close_out();
    endtask

    // Main sequence
    initial begin
        void'($urandom(90294));
        cfg_rand = 8'($urandom());
        boot_ctrl <= 8'($urandom()) & 8'h04;
        boot_config <= 8'($urandom());
        boot_wd_early_alert_control <= 8'($urandom());
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(4'h0, {12'h000, boot_wd_early_alert_control[3:0], boot_config, boot_ctrl}, 32'h000FFF86);
        rd(4'h4, 32'h0, 32'h80010101);
        wr(4'h0, 4'h2, {16'h0, cfg_rand, 8'h00});
        rd(4'h0, {16'h0, cfg_rand, 8'h00}, 32'h0000FF00);
        idle();
        wr_protect <= 1'b1;
        wr(4'h0, 4'h2, {16'h0, ~cfg_rand, 8'h00});
        wr(4'h4, 4'h2, 32'h00000100);
        rd(4'h0, {16'h0, cfg_rand, 8'h00}, 32'h0000FF00);
        rd(4'h4, 32'h0, 32'h00000101);
        idle();
        wr_protect <= 1'b0;
        wr(4'h4, 4'h2, 32'h00000100);
        wr(4'h4, 4'h1, 32'h00000000);
        rd(4'h4, 32'h00000101, 32'h00000101);
        wr(4'h0, 4'h6, 32'h00000100);
        idle();
        wr(4'h0, 4'h1, 32'h00000002);
        rd(4'h0, 32'h00000102, 32'h0000FF86);
        rd(4'h4, 32'h80000000, 32'h80000000);
        wr(4'h8, 4'h1, 32'h000000A5);
        wait_for(3, 1'b1, 2);
        wait_for(3, 1'b0, 300);
        wait_for(0, 1'b1, 300);
        wr(4'h0, 4'h2, 32'h0000FF00);
        rd(4'h0, 32'h00000100, 32'h0000FF00);
        wait_for(1, 1'b1, 2000);
        rd(4'h4, 32'h00010101, 32'h00010101);
        wr(4'h4, 4'h4, 32'h00010000);
        rd(4'h4, 32'h0, 32'h00010000);
        wait_for(1, 1'b0, 2);
        wr(4'h4, 4'h1, 32'h00000001);
        rd(4'h4, 32'h0, 32'h00000101);
        wait_for(2, 1'b1, 3000);
        wait_for(2, 1'b0, 300);
        wr(4'h8, 4'h1, 32'h0000005A);
        wait_for(2, 1'b1, 60);
        wait_for(2, 1'b0, 300);
        idle();
        wr(4'h0, 4'h1, 32'h00000000);
        idle();
        wait_for(0, 1'b0, 2);
        wr(4'h0, 4'h1, 32'h00000006);
        idle();
        rd(4'h0, 32'h00000106, 32'h00000086);
        wr(4'h8, 4'h1, 32'h000000A5);
        wait_for(2, 1'b1, 60);
        wait_for(2, 1'b0, 300);
        wr(4'h0, 4'h1, 32'h00000080);
        wr(4'h0, 4'h1, 32'h00000002);
        wait_for(3, 1'b0, 300);
        wr(4'h0, 4'h2, 32'h0000FF00);
        idle();
        rd(4'h0, 32'h00000184, 32'h0000FF86);
        wait_for(0, 1'b1, 2);
        close_out();
    end

    // Guard against a hang anywhere in the run
    initial begin
        #300000;
        failures++;
        close_out();
    end
endmodule // watchdog_register_interface_bench
`default_nettype wire
